// [ahps_afe_model.sv]
// Analog front end stand-in: comparator against a per-channel level, or mid-scale on the reference input.
// Assumes straight binary SUCCESSIVE_APPROX_REG with keep-bit when trial is at or below level.
module ahps_afe_model
#(
    parameter logic [6:0] LOW_BITS = 7'h35
)
(
    input  wire logic [9:0] SAR_OUT,
    input  wire logic       HOLD,
    input  wire logic [2:0] MUX_SEL,
    input  wire logic       REF_SELECT,
    output logic            COMP_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] level;
    // Reference input sits at mid-scale; each channel has its own level
    assign level   = REF_SELECT ? 10'h200 : {MUX_SEL, LOW_BITS};
    assign COMP_IN = HOLD && (SAR_OUT <= level);
endmodule

// [ahps_defines.vh]
// Constants for the host port conversion sequencer.
// Assumes a single 250 MHz system clock; the conversion clock is an enable.
`ifndef AHPS_DEFINES_VH
`define AHPS_DEFINES_VH

// Control word layout
`define AHPS_CW_W        10
`define AHPS_CW_RESET    10'h000
`define AHPS_CH1_LSB     0
`define AHPS_CH1_MSB     2
`define AHPS_CH2_LSB     3
`define AHPS_CH2_MSB     5
`define AHPS_DUAL_BIT    6
`define AHPS_HST_BIT     7
`define AHPS_PD_BIT      8
`define AHPS_POL_BIT     9

// Result and approximation register
`define AHPS_RES_W       10
`define AHPS_RES_ZERO    10'h000
`define AHPS_SAR_TRIAL   10'h200

// Clock and timing
`define AHPS_CLK_MHZ     250
`define AHPS_DIV_W       5
`define AHPS_DIV_LAST    5'h1F
`define AHPS_DIV_ZERO    5'h00
`define AHPS_HOLD_DLY_NS 40
`define AHPS_DLY_CYC     ((`AHPS_HOLD_DLY_NS * `AHPS_CLK_MHZ) / 1000)
`define AHPS_DLY_W       4
`define AHPS_DLY_ZERO    4'h0
`define AHPS_DLY_ONE     4'h1

// Conversion sequence counts, in conversion clock cycles
`define AHPS_CNT_W       4
`define AHPS_CNT_ZERO    4'h0
`define AHPS_CNT_ONE     4'h1
`define AHPS_ACQ_CYC     4'h4
`define AHPS_DEC1_CYC    4'h2
`define AHPS_DEC2_CYC    4'h4
`define AHPS_DEC3_CYC    4'h5
`define AHPS_DEC_LAST    4'hC
`define AHPS_CONV_LAST   4'hD
`define AHPS_NO_BIT      4'hF
`define AHPS_IDX_B1      4'h9
`define AHPS_IDX_B2      4'h8

`endif

// [ahps_seq.v]
// Host port conversion sequencer for a 10-bit multichannel SUCCESSIVE_APPROX_REG converter.
// Assumes the host strobes, data bus and comparator are asynchronous
// to CLK and that the analog track/hold, mux and DAC follow the outputs.
`include "ahps_defines.vh"

module ahps_seq
(
    input  wire                    CLK,
    input  wire                    RESET_N,
    input  wire                    CS_N,
    input  wire                    WR_N,
    input  wire                    RD_N,
    input  wire [`AHPS_CW_W-1:0]   DATA_IN,
    input  wire                    COMP_IN,
    output reg  [`AHPS_RES_W-1:0]  DATA_OUT,
    output reg                     DATA_OE,
    output reg                     BUSY_INT,
    output reg                     HOLD,
    output reg  [`AHPS_RES_W-1:0]  SAR_OUT,
    output reg  [2:0]              MUX_SEL,
    output reg                     REF_SELECT,
    output reg                     POWER_DOWN
);

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_ACQ  = 3'b010;
    localparam [2:0] S_CONV = 3'b100;

    // Decision delay in CLK cycles, cut to the delay counter width
    localparam integer               DLY_INT = `AHPS_DLY_CYC;
    localparam [`AHPS_DLY_W-1:0]     DLY_CYC = DLY_INT[`AHPS_DLY_W-1:0];

    // Bit position decided at a given conversion count, or none
    function [`AHPS_CNT_W-1:0] dec_index;
        input [`AHPS_CNT_W-1:0] c;
        begin
            if (c == `AHPS_DEC1_CYC)
                dec_index = `AHPS_IDX_B1;
            else if (c == `AHPS_DEC2_CYC)
                dec_index = `AHPS_IDX_B2;
            else if (c >= `AHPS_DEC3_CYC && c <= `AHPS_DEC_LAST)
                dec_index = `AHPS_DEC_LAST - c;
            else
                dec_index = `AHPS_NO_BIT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    reg  [2:0]               strb_m;
    reg  [2:0]               strb_s;
    reg  [`AHPS_CW_W-1:0]    din_m;
    reg  [`AHPS_CW_W-1:0]    din_s;
    reg                      comp_m;
    reg                      comp_s;

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            strb_m <= 3'h7;
            strb_s <= 3'h7;
            din_m  <= `AHPS_CW_RESET;
            din_s  <= `AHPS_CW_RESET;
            comp_m <= 1'b0;
            comp_s <= 1'b0;
        end
        else
        begin
            strb_m <= {CS_N, WR_N, RD_N};
            strb_s <= strb_m;
            din_m  <= DATA_IN;
            din_s  <= din_m;
            comp_m <= COMP_IN;
            comp_s <= comp_m;
        end
    end

    wire cs_s = strb_s[2];
    wire wr_s = strb_s[1];
    wire rd_s = strb_s[0];

    wire wr_act = !cs_s && !wr_s && rd_s;
    wire rd_act = !cs_s && !rd_s && wr_s;

    reg  wr_act_q;
    reg  rd_act_q;

    wire wr_lead  = wr_act && !wr_act_q;
    wire wr_trail = !wr_act && wr_act_q;
    wire rd_lead  = rd_act && !rd_act_q;
    wire rd_trail = !rd_act && rd_act_q;

    ////////////////////////////////////////////////////////////////////
    // Conversion clock enable and 40 ns decision delay

    reg  [`AHPS_DIV_W-1:0]   div_cnt;
    reg  [`AHPS_DLY_W-1:0]   dly_cnt;
    reg                      step;

    // Step fires a fixed delay after each conversion clock edge;
    // hold and bit decisions all land on it.
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            div_cnt <= `AHPS_DIV_ZERO;
            dly_cnt <= `AHPS_DLY_ZERO;
            step    <= 1'b0;
        end
        else
        begin
            step <= 1'b0;
            if (div_cnt == `AHPS_DIV_LAST)
                div_cnt <= `AHPS_DIV_ZERO;
            else
                div_cnt <= div_cnt + 1'b1;
            if (div_cnt == `AHPS_DIV_LAST)
                dly_cnt <= DLY_CYC;
            else if (dly_cnt != `AHPS_DLY_ZERO)
            begin
                dly_cnt <= dly_cnt - 1'b1;
                if (dly_cnt == `AHPS_DLY_ONE)
                    step <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control word, sequencer and result registers

    reg  [2:0]               state;
    reg  [`AHPS_CW_W-1:0]    ctrl;
    reg  [`AHPS_CNT_W-1:0]   cnt;
    reg  [`AHPS_RES_W-1:0]   successive_approx_reg;
    reg  [`AHPS_RES_W-1:0]   res1;
    reg  [`AHPS_RES_W-1:0]   res2;
    reg                      second;
    reg                      rd_ptr;

    wire [`AHPS_CNT_W-1:0]   bidx = dec_index(cnt);
    wire                     dual = ctrl[`AHPS_DUAL_BIT];
    wire                     pol  = ctrl[`AHPS_POL_BIT];

    // Decision clears the trial bit on a low comparator, sets the next
    reg  [`AHPS_RES_W-1:0]   next_sar;
    integer                  i;

    always @*
    begin
        next_sar = successive_approx_reg;
        for (i = 0; i < `AHPS_RES_W; i = i + 1)
        begin
            if (bidx == i[`AHPS_CNT_W-1:0])
            begin
                if (!comp_s)
                    next_sar[i] = 1'b0;
                if (i > 0)
                    next_sar[i-1] = 1'b1;
            end
        end
    end

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            state    <= S_IDLE;
            ctrl     <= `AHPS_CW_RESET;
            cnt      <= `AHPS_CNT_ZERO;
            successive_approx_reg      <= `AHPS_RES_ZERO;
            res1     <= `AHPS_RES_ZERO;
            res2     <= `AHPS_RES_ZERO;
            second   <= 1'b0;
            rd_ptr   <= 1'b0;
            BUSY_INT <= 1'b1;
            HOLD     <= 1'b0;
            DATA_OUT <= `AHPS_RES_ZERO;
        end
        else
        begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_lead)
            begin
                // Any write halts a running conversion
                if (state != S_IDLE)
                begin
                    state  <= S_IDLE;
                    HOLD   <= 1'b0;
                    successive_approx_reg    <= `AHPS_RES_ZERO;
                    if (din_s[`AHPS_PD_BIT])
                        BUSY_INT <= 1'b1;
                end
            end
            else if (wr_trail)
            begin
                ctrl   <= din_s;
                rd_ptr <= 1'b0;
                if (!din_s[`AHPS_PD_BIT])
                begin
                    state    <= S_ACQ;
                    cnt      <= `AHPS_CNT_ZERO;
                    second   <= 1'b0;
                    HOLD     <= 1'b0;
                    successive_approx_reg      <= `AHPS_RES_ZERO;
                    BUSY_INT <= din_s[`AHPS_POL_BIT];
                end
            end
            else if (rd_lead)
            begin
                if (state != S_IDLE)
                begin
                    state <= S_IDLE;
                    HOLD  <= 1'b0;
                    successive_approx_reg   <= `AHPS_RES_ZERO;
                end
                DATA_OUT <= rd_ptr ? res2 : res1;
            end
            else if (rd_trail)
            begin
                if (dual)
                    rd_ptr <= !rd_ptr;
            end
            else if (step)
            begin
                case (state)
                    S_ACQ:
                    begin
                        if (cnt == `AHPS_ACQ_CYC)
                        begin
                            state <= S_CONV;
                            HOLD  <= 1'b1;
                            cnt   <= `AHPS_CNT_ZERO;
                            successive_approx_reg   <= `AHPS_SAR_TRIAL;
                        end
                        else
                            cnt <= cnt + `AHPS_CNT_ONE;
                    end
                    S_CONV:
                    begin
                        if (cnt == `AHPS_CONV_LAST)
                        begin
                            cnt <= `AHPS_CNT_ZERO;
                            if (dual && !second)
                            begin
                                res1   <= successive_approx_reg;
                                second <= 1'b1;
                                successive_approx_reg    <= `AHPS_SAR_TRIAL;
                            end
                            else
                            begin
                                if (second)
                                    res2 <= successive_approx_reg;
                                else
                                    res1 <= successive_approx_reg;
                                BUSY_INT <= !pol;
                                state    <= S_IDLE;
                                HOLD     <= 1'b0;
                                successive_approx_reg      <= `AHPS_RES_ZERO;
                            end
                        end
                        else
                        begin
                            cnt <= cnt + `AHPS_CNT_ONE;
                            successive_approx_reg <= next_sar;
                        end
                    end
                    default:
                        cnt <= `AHPS_CNT_ZERO;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Analog side controls and bus enable

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            DATA_OE    <= 1'b0;
            SAR_OUT    <= `AHPS_RES_ZERO;
            MUX_SEL    <= 3'h0;
            REF_SELECT <= 1'b0;
            POWER_DOWN <= 1'b0;
        end
        else
        begin
            DATA_OE    <= rd_act;
            SAR_OUT    <= successive_approx_reg;
            REF_SELECT <= ctrl[`AHPS_HST_BIT];
            if (ctrl[`AHPS_HST_BIT])
                MUX_SEL <= 3'h0;
            else if (second)
                MUX_SEL <= ctrl[`AHPS_CH2_MSB:`AHPS_CH2_LSB];
            else
                MUX_SEL <= ctrl[`AHPS_CH1_MSB:`AHPS_CH1_LSB];
            POWER_DOWN <= ctrl[`AHPS_PD_BIT];
        end
    end

endmodule

// [ahps_seq_asserts.sv]
// Checker for the host port conversion sequencer.
// Sees only the top module ports; bound to every ahps_seq instance.
module ahps_seq_chk
(
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       CS_N,
    input wire logic       WR_N,
    input wire logic       RD_N,
    input wire logic [9:0] DATA_IN,
    input wire logic       DATA_OE,
    input wire logic       BUSY_INT,
    input wire logic       HOLD,
    input wire logic [9:0] SAR_OUT,
    input wire logic [2:0] MUX_SEL,
    input wire logic       REF_SELECT,
    input wire logic       POWER_DOWN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    ////////////////////////////////////////////////////////////////////////
    a_bus_float: assert property (CS_N [*5] |-> !DATA_OE)
        else $error("bus driven while deselected");
    a_oe_no_read: assert property (RD_N [*5] |-> !DATA_OE)
        else $error("bus driven without a read");
    a_oe_on_read: assert property ((!CS_N && !RD_N && WR_N) [*5] |-> DATA_OE)
        else $error("bus not driven during read");
    a_pd_no_hold: assert property (POWER_DOWN |-> !HOLD)
        else $error("hold active in powerdown");
    a_test_mux_zero: assert property (REF_SELECT && HOLD |-> MUX_SEL == 3'h0)
        else $error("channel selected in test mode");
    a_hold_trial: assert property ($rose(HOLD) |-> ##[0:2] SAR_OUT == 10'h200)
        else $error("first trial value wrong at hold");
    // Only normal-polarity starts; the flag must drop once the word lands
    a_wr_start: assert property ($rose(WR_N) && !CS_N && RD_N && !DATA_IN[8]
        && !DATA_IN[9] |-> ##[2:4] !BUSY_INT)
        else $error("write did not start conversion");
    a_ctrl_update: assert property ($rose(WR_N) && !CS_N && RD_N |-> ##4
        (POWER_DOWN == DATA_IN[8] && REF_SELECT == DATA_IN[7]))
        else $error("control bits not loaded");

    c_hold: cover property ($rose(HOLD));
    c_pd: cover property ($rose(POWER_DOWN));
    c_test: cover property (REF_SELECT && HOLD);
endmodule

bind ahps_seq ahps_seq_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N),
    .WR_N(WR_N), .RD_N(RD_N), .DATA_IN(DATA_IN), .DATA_OE(DATA_OE),
    .BUSY_INT(BUSY_INT), .HOLD(HOLD), .SAR_OUT(SAR_OUT), .MUX_SEL(MUX_SEL),
    .REF_SELECT(REF_SELECT), .POWER_DOWN(POWER_DOWN));

// [ahps_seq_tb.sv]
// Self-checking bench for the host port conversion sequencer.
// Assumes the front end model supplies the comparator decisions.
module ahps_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLK = 0, RESET_N = 0, CS_N = 1, WR_N = 1, RD_N = 1;
    logic [9:0] DATA_IN = 10'h000;
    wire        COMP_IN, DATA_OE, BUSY_INT, HOLD, REF_SELECT, POWER_DOWN;
    wire  [9:0] DATA_OUT, SAR_OUT;
    wire  [2:0] MUX_SEL;
    int         err_total = 0, comparisons = 0;
    logic [9:0] rv;

    initial forever #2 CLK = ~CLK;

    ahps_seq u_ahps_seq (.CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N), .WR_N(WR_N),
        .RD_N(RD_N), .DATA_IN(DATA_IN), .COMP_IN(COMP_IN), .DATA_OUT(DATA_OUT),
        .DATA_OE(DATA_OE), .BUSY_INT(BUSY_INT), .HOLD(HOLD), .SAR_OUT(SAR_OUT),
        .MUX_SEL(MUX_SEL), .REF_SELECT(REF_SELECT), .POWER_DOWN(POWER_DOWN));
    ahps_afe_model u_ahps_afe_model (.SAR_OUT(SAR_OUT), .HOLD(HOLD),
        .MUX_SEL(MUX_SEL), .REF_SELECT(REF_SELECT), .COMP_IN(COMP_IN));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] lvl(logic [2:0] c);
        return {c, 7'h35};
    endfunction
    task automatic chk(string n, logic [9:0] e, logic [9:0] s);
        comparisons++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task automatic chkb(string n, logic e, logic s);
        comparisons++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %b seen %b", n, e, s);
            err_total++;
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic wr(logic [9:0] w);
        @(posedge CLK);
        CS_N    <= 1'b0;
        WR_N    <= 1'b0;
        DATA_IN <= w;
        cyc(4);
        WR_N <= 1'b1;
        cyc(4);
        CS_N <= 1'b1;
        cyc(3);
    endtask
    task automatic rd(output logic [9:0] v);
        @(posedge CLK);
        CS_N <= 1'b0;
        RD_N <= 1'b0;
        cyc(5);
        v = DATA_OUT;
        chkb("bus_enable", 1'b1, DATA_OE);
        RD_N <= 1'b1;
        CS_N <= 1'b1;
        cyc(4);
    endtask
    task automatic wait_busy(logic l);
        int i;
        for (i = 0; i < 3000 && BUSY_INT !== l; i++)
            @(posedge CLK);
        chkb("busy_wait", l, BUSY_INT);
    endtask
    // Write, watch the flag through the run, then three reads
    task automatic run(logic [9:0] w, logic [9:0] e1, logic [9:0] e2);
        wr(w);
        chkb("flag_busy", w[9], BUSY_INT);
        wait_busy(~w[9]);
        rd(rv);
        chk("first_result", e1, rv);
        rd(rv);
        chk("next_result", w[6] ? e2 : e1, rv);
        rd(rv);
        chk("third_result", e1, rv);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(8);
        RESET_N <= 1'b1;
        cyc(4);
        chkb("idle_flag", 1'b1, BUSY_INT);
        chkb("idle_pd", 1'b0, POWER_DOWN);
        for (int c = 0; c < 8; c++)
            run({7'h00, c[2:0]}, lvl(c[2:0]), 10'h000);
        run(10'h06A, lvl(3'h2), lvl(3'h5));
        run(10'h0FF, 10'h200, 10'h200);
        run(10'h203, lvl(3'h3), 10'h000);
        // Powerdown from idle keeps results; wake write reconfigures
        run(10'h004, lvl(3'h4), 10'h000);
        wr(10'h104);
        chkb("pd_on", 1'b1, POWER_DOWN);
        rd(rv);
        chk("pd_keep", lvl(3'h4), rv);
        run(10'h046, lvl(3'h6), lvl(3'h0));
        chkb("pd_off", 1'b0, POWER_DOWN);
        // Powerdown in mid-conversion aborts and raises the flag;
        // the wait puts the abort inside the hold phase
        wr(10'h001);
        cyc(250);
        wr(10'h101);
        chkb("abort_flag", 1'b1, BUSY_INT);
        chkb("abort_hold", 1'b0, HOLD);
        run(10'h001, lvl(3'h1), 10'h000);
        // Read during hold stops the conversion; flag left as it was
        wr(10'h002);
        cyc(200);
        chkb("mid_hold", 1'b1, HOLD);
        rd(rv);
        chkb("read_abort", 1'b0, HOLD);
        cyc(800);
        chkb("read_abort_flag", 1'b0, BUSY_INT);
        @(posedge CLK);
        RD_N <= 1'b0;
        cyc(6);
        chkb("float", 1'b0, DATA_OE);
        RD_N <= 1'b1;
        cyc(4);
        wrap_up;
    end

    initial
    begin
        cyc(60000);
        err_total++;
        wrap_up;
    end
endmodule
